// *** pkg/lbcc_map.svh ***
// offsets, field positions, reset values and codes of the commissioning controller
`ifndef LBCC_MAP_SVH
`define LBCC_MAP_SVH

// ==================================================
// register offsets
`define LBCC_ADDR_BUS1_PROGRESS 16'h7611
`define LBCC_ADDR_BUS2_PROGRESS 16'h7612
`define LBCC_ADDR_BUS1_CONFIG   16'h9D3E
`define LBCC_ADDR_BUS2_CONFIG   16'h9D3F

// ==================================================
// configuration register fields
`define LBCC_CFG_TRIG_LSB  11
`define LBCC_CFG_TRIG_MSB  15
`define LBCC_CFG_RESET_VAL 16'h0000

// trigger index inside the five-bit trigger field
`define LBCC_TRIG_RESET    0
`define LBCC_TRIG_DISCOVER 1
`define LBCC_TRIG_REPLACE  2
`define LBCC_TRIG_ADD      3
`define LBCC_TRIG_CLEAR    4

// ==================================================
// progress and address pool
`define LBCC_PCT_FULL    7'h64
`define LBCC_SLOT_MAX    5'h10
`define LBCC_LFSR_SEED   16'hACE1
`define LBCC_ADDR_FIRST  5'h01
`endif

// *** pkg/lbcc_pkg.sv ***
// types and shared helper functions of the commissioning controller
`default_nettype none
`include "lbcc_map.svh"
package lbcc_pkg;

   // ==================================================
   // gear link operations
   typedef enum logic [2:0] {
      LBCC_OP_NONE    = 3'b000,
      LBCC_OP_RESET   = 3'b001,
      LBCC_OP_CLEAR   = 3'b010,
      LBCC_OP_PROGRAM = 3'b011
   } lbcc_op_type;

   typedef enum logic [1:0] {
      LBCC_ST_IDLE = 2'b00,
      LBCC_ST_PICK = 2'b01,
      LBCC_ST_SEND = 2'b10
   } lbcc_state_type;

   // ==================================================
   // helpers
   function automatic logic [4:0] lbcc_rise(input logic [4:0] old_v, input logic [4:0] new_v);
      return new_v & ~old_v;
   endfunction

   // first set slot at or after start, wrapping round
   function automatic logic [3:0] lbcc_pick(input logic [15:0] pool, input logic [3:0] start);
      logic [3:0] idx;
      logic [3:0] res;
      logic       hit;
      res = 4'h0;
      hit = 1'b0;
      for (int i = 0; i < 16; i++) begin
         idx = start + i[3:0];
         if (!hit && pool[idx]) begin
            res = idx;
            hit = 1'b1;
         end
      end
      return res;
   endfunction

   // count of 16 slots scaled to 0..100
   function automatic logic [6:0] lbcc_pct(input logic [4:0] n);
      logic [11:0] p;
      p = {7'h00, n} * {5'h00, `LBCC_PCT_FULL};
      return p[10:4];
   endfunction

endpackage
`default_nettype wire

// *** pkg/lbcc_chan_if.sv ***
// link between the register front end and one channel engine
`timescale 1ns/1ns
`default_nettype none
interface lbcc_chan_if;
   logic [4:0]  trig;
   logic [15:0] fault_flags;
   logic [15:0] known;
   logic [6:0]  progress;
   logic        busy;

   modport ctrl (output trig, output fault_flags, input known, input progress, input busy);
   modport chan (input trig, input fault_flags, output known, output progress, output busy);
endinterface
`default_nettype wire

// *** rtl/lbcc_channel.sv ***
// command engine for one lighting bus channel
`timescale 1ns/1ns
`default_nettype none
`include "lbcc_map.svh"
module lbcc_channel
   import lbcc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   lbcc_chan_if.chan       ch,
   output logic            gear_req,
   output logic [2:0]      gear_op,
   output logic [4:0]      gear_addr,
   input  wire logic       gear_done,
   input  wire logic       gear_found
);

   // ==================================================
   // state
   lbcc_state_type state_q, state_d;
   lbcc_op_type    op_q, op_d;
   logic [15:0]    pool_q, pool_d;
   logic [15:0]    known_q, known_d;
   logic [15:0]    lfsr_q, lfsr_d;
   logic [4:0]     count_q, count_d;
   logic [6:0]     prog_q, prog_d;
   logic [4:0]     addr_q, addr_d;
   logic [3:0]     slot_q, slot_d;
   logic           req_q, req_d;
   logic           bcast_q, bcast_d;
   logic           lowest_q, lowest_d;
   logic           disc_q, disc_d;
   logic [3:0]     pick;

   always_comb begin
      state_d  = state_q;
      op_d     = op_q;
      pool_d   = pool_q;
      known_d  = known_q;
      count_d  = count_q;
      prog_d   = prog_q;
      addr_d   = addr_q;
      slot_d   = slot_q;
      req_d    = req_q;
      bcast_d  = bcast_q;
      lowest_d = lowest_q;
      disc_d   = disc_q;
      lfsr_d   = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      pick     = lbcc_pick(pool_q, lowest_q ? 4'h0 : lfsr_q[3:0]);
      case (state_q)
         LBCC_ST_IDLE: begin
            // triggers are only looked at here, so a command never interleaves another
            if (ch.trig[`LBCC_TRIG_RESET]) begin
               known_d = 16'h0000;
               bcast_d = 1'b1;
               op_d    = LBCC_OP_RESET;
               req_d   = 1'b1;
               state_d = LBCC_ST_SEND;
            end else if (ch.trig[`LBCC_TRIG_CLEAR]) begin
               known_d = 16'h0000;
               bcast_d = 1'b1;
               op_d    = LBCC_OP_CLEAR;
               req_d   = 1'b1;
               state_d = LBCC_ST_SEND;
            end else if (ch.trig[`LBCC_TRIG_DISCOVER]) begin
               pool_d   = ~known_q;
               lowest_d = 1'b0;
               disc_d   = 1'b1;
               count_d  = 5'h00;
               prog_d   = 7'h00;
               bcast_d  = 1'b0;
               state_d  = LBCC_ST_PICK;
            end else if (ch.trig[`LBCC_TRIG_ADD]) begin
               pool_d   = ~known_q;
               lowest_d = 1'b1;
               disc_d   = 1'b0;
               bcast_d  = 1'b0;
               state_d  = LBCC_ST_PICK;
            end else if (ch.trig[`LBCC_TRIG_REPLACE] && (ch.fault_flags != 16'h0000)) begin
               pool_d   = ch.fault_flags;
               lowest_d = 1'b0;
               disc_d   = 1'b0;
               bcast_d  = 1'b0;
               state_d  = LBCC_ST_PICK;
            end
         end
         LBCC_ST_PICK: begin
            if (pool_q == 16'h0000) begin
               if (disc_q) begin
                  prog_d = `LBCC_PCT_FULL;
               end
               state_d = LBCC_ST_IDLE;
            end else begin
               slot_d  = pick;
               addr_d  = {1'b0, pick} + `LBCC_ADDR_FIRST;
               op_d    = LBCC_OP_PROGRAM;
               req_d   = 1'b1;
               state_d = LBCC_ST_SEND;
            end
         end
         LBCC_ST_SEND: begin
            if (gear_done) begin
               req_d = 1'b0;
               op_d  = LBCC_OP_NONE;
               if (bcast_q) begin
                  state_d = LBCC_ST_IDLE;
               end else if (gear_found) begin
                  known_d[slot_q] = 1'b1;
                  pool_d[slot_q]  = 1'b0;
                  count_d         = count_q + 5'h01;
                  if (disc_q) begin
                     prog_d = lbcc_pct(count_q + 5'h01);
                  end
                  state_d = LBCC_ST_PICK;
               end else begin
                  // no unaddressed gear answered: the scan is over
                  if (disc_q) begin
                     prog_d = `LBCC_PCT_FULL;
                  end
                  state_d = LBCC_ST_IDLE;
               end
            end
         end
         default: begin
            state_d = LBCC_ST_IDLE;
            req_d   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q  <= LBCC_ST_IDLE;
         op_q     <= LBCC_OP_NONE;
         pool_q   <= 16'h0000;
         known_q  <= 16'h0000;
         lfsr_q   <= `LBCC_LFSR_SEED;
         count_q  <= 5'h00;
         prog_q   <= 7'h00;
         addr_q   <= 5'h00;
         slot_q   <= 4'h0;
         req_q    <= 1'b0;
         bcast_q  <= 1'b0;
         lowest_q <= 1'b0;
         disc_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         op_q     <= op_d;
         pool_q   <= pool_d;
         known_q  <= known_d;
         lfsr_q   <= lfsr_d;
         count_q  <= count_d;
         prog_q   <= prog_d;
         addr_q   <= addr_d;
         slot_q   <= slot_d;
         req_q    <= req_d;
         bcast_q  <= bcast_d;
         lowest_q <= lowest_d;
         disc_q   <= disc_d;
      end
   end

   assign gear_req    = req_q;
   assign gear_op     = op_q;
   assign gear_addr   = addr_q;
   assign ch.known    = known_q;
   assign ch.progress = prog_q;
   assign ch.busy     = (state_q != LBCC_ST_IDLE);

endmodule
`default_nettype wire

// *** rtl/lbcc_top.sv ***
// commissioning trigger logic for two lighting bus channels
`timescale 1ns/1ns
`default_nettype none
`include "lbcc_map.svh"
module lbcc_top
   import lbcc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_ack,
   output logic             reg_err,
   input  wire logic [15:0] bus1_fault_flags,
   input  wire logic [15:0] bus2_fault_flags,
   output logic             bus1_gear_req,
   output logic      [2:0]  bus1_gear_op,
   output logic      [4:0]  bus1_gear_addr,
   input  wire logic        bus1_gear_done,
   input  wire logic        bus1_gear_found,
   output logic             bus2_gear_req,
   output logic      [2:0]  bus2_gear_op,
   output logic      [4:0]  bus2_gear_addr,
   input  wire logic        bus2_gear_done,
   input  wire logic        bus2_gear_found,
   output logic             bus1_single_ok,
   output logic             bus2_single_ok,
   output logic             bus1_busy,
   output logic             bus2_busy
);

   // ==================================================
   // channel links
   lbcc_chan_if link1 ();
   lbcc_chan_if link2 ();

   // ==================================================
   // register front end state
   logic [15:0] bus1_config_q, bus1_config_d;
   logic [15:0] bus2_config_q, bus2_config_d;
   logic [4:0]  trig1_q, trig1_d;
   logic [4:0]  trig2_q, trig2_d;
   logic [15:0] rdata_q, rdata_d;
   logic        ack_q, ack_d;
   logic        err_q, err_d;
   logic        single1_q, single1_d;
   logic        single2_q, single2_d;
   logic        busy1_q, busy1_d;
   logic        busy2_q, busy2_d;
   logic        hit_cfg1;
   logic        hit_cfg2;
   logic        hit_prog1;
   logic        hit_prog2;

   always_comb begin
      hit_cfg1  = (reg_addr == `LBCC_ADDR_BUS1_CONFIG);
      hit_cfg2  = (reg_addr == `LBCC_ADDR_BUS2_CONFIG);
      hit_prog1 = (reg_addr == `LBCC_ADDR_BUS1_PROGRESS);
      hit_prog2 = (reg_addr == `LBCC_ADDR_BUS2_PROGRESS);

      bus1_config_d = bus1_config_q;
      bus2_config_d = bus2_config_q;
      trig1_d       = 5'h00;
      trig2_d       = 5'h00;
      rdata_d       = rdata_q;
      ack_d         = 1'b0;
      err_d         = 1'b0;

      if (reg_wr) begin
         // writes win over a read presented in the same cycle
         ack_d = 1'b1;
         if (hit_cfg1) begin
            bus1_config_d = reg_wdata;
            trig1_d = lbcc_rise(bus1_config_q[`LBCC_CFG_TRIG_MSB:`LBCC_CFG_TRIG_LSB],
                                reg_wdata[`LBCC_CFG_TRIG_MSB:`LBCC_CFG_TRIG_LSB]);
         end else if (hit_cfg2) begin
            bus2_config_d = reg_wdata;
            trig2_d = lbcc_rise(bus2_config_q[`LBCC_CFG_TRIG_MSB:`LBCC_CFG_TRIG_LSB],
                                reg_wdata[`LBCC_CFG_TRIG_MSB:`LBCC_CFG_TRIG_LSB]);
         end else begin
            // progress registers are read only; anything else is unmapped
            err_d = 1'b1;
         end
      end else if (reg_rd) begin
         ack_d = 1'b1;
         if (hit_cfg1) begin
            rdata_d = bus1_config_q;
         end else if (hit_cfg2) begin
            rdata_d = bus2_config_q;
         end else if (hit_prog1) begin
            rdata_d = {9'h000, link1.progress};
         end else if (hit_prog2) begin
            rdata_d = {9'h000, link2.progress};
         end else begin
            rdata_d = 16'h0000;
            err_d   = 1'b1;
         end
      end

      // a channel with no known address allows broadcast control only
      single1_d = (link1.known != 16'h0000);
      single2_d = (link2.known != 16'h0000);
      busy1_d   = link1.busy;
      busy2_d   = link2.busy;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bus1_config_q <= `LBCC_CFG_RESET_VAL;
         bus2_config_q <= `LBCC_CFG_RESET_VAL;
         trig1_q       <= 5'h00;
         trig2_q       <= 5'h00;
         rdata_q       <= 16'h0000;
         ack_q         <= 1'b0;
         err_q         <= 1'b0;
         single1_q     <= 1'b0;
         single2_q     <= 1'b0;
         busy1_q       <= 1'b0;
         busy2_q       <= 1'b0;
      end else begin
         bus1_config_q <= bus1_config_d;
         bus2_config_q <= bus2_config_d;
         trig1_q       <= trig1_d;
         trig2_q       <= trig2_d;
         rdata_q       <= rdata_d;
         ack_q         <= ack_d;
         err_q         <= err_d;
         single1_q     <= single1_d;
         single2_q     <= single2_d;
         busy1_q       <= busy1_d;
         busy2_q       <= busy2_d;
      end
   end

   // ==================================================
   // trigger and fault hand-off
   // a trigger pulse seen by a busy engine is simply dropped, never queued
   assign link1.trig        = trig1_q;
   assign link2.trig        = trig2_q;
   assign link1.fault_flags = bus1_fault_flags;
   assign link2.fault_flags = bus2_fault_flags;

   // ==================================================
   // channel engines
   lbcc_channel u_chan1 (
      .clock      (clock),
      .rst_n      (rst_n),
      .ch         (link1.chan),
      .gear_req   (bus1_gear_req),
      .gear_op    (bus1_gear_op),
      .gear_addr  (bus1_gear_addr),
      .gear_done  (bus1_gear_done),
      .gear_found (bus1_gear_found)
   );

   // second bus acts only on its own gear
   lbcc_channel u_chan2 (
      .clock      (clock),
      .rst_n      (rst_n),
      .ch         (link2.chan),
      .gear_req   (bus2_gear_req),
      .gear_op    (bus2_gear_op),
      .gear_addr  (bus2_gear_addr),
      .gear_done  (bus2_gear_done),
      .gear_found (bus2_gear_found)
   );

   // ==================================================
   // outputs
   assign reg_rdata      = rdata_q;
   assign reg_ack        = ack_q;
   assign reg_err        = err_q;
   assign bus1_single_ok = single1_q;
   assign bus2_single_ok = single2_q;
   assign bus1_busy      = busy1_q;
   assign bus2_busy      = busy2_q;

endmodule
`default_nettype wire

// *** tb/lbcc_top_sva.sv ***
// concurrent checks on the commissioning controller ports
`timescale 1ns/1ns
`default_nettype none
module lbcc_top_sva (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_ack,
   input wire logic        reg_err,
   input wire logic        bus1_gear_req,
   input wire logic [2:0]  bus1_gear_op,
   input wire logic [4:0]  bus1_gear_addr,
   input wire logic        bus1_gear_done,
   input wire logic        bus2_gear_req,
   input wire logic [2:0]  bus2_gear_op,
   input wire logic [4:0]  bus2_gear_addr,
   input wire logic        bus1_single_ok,
   input wire logic        bus1_busy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ==================================================
   // register port
   ack_after_req_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("register access not acknowledged");
   progress_ro_a: assert property (reg_wr && reg_addr[15:4] == 12'h761 |=> reg_err)
      else $error("write to progress register not refused");
   progress_range_a: assert property (reg_rd && !reg_wr && reg_addr == 16'h7611 |=> reg_rdata <= 16'h0064)
      else $error("progress above full scale");
   // ==================================================
   // gear link: one transaction at a time
   req_hold_a: assert property (bus1_gear_req && !bus1_gear_done
      |=> bus1_gear_req && $stable(bus1_gear_op) && $stable(bus1_gear_addr))
      else $error("gear request changed before done");
   req_drop_a: assert property (bus1_gear_req && bus1_gear_done |=> !bus1_gear_req)
      else $error("gear request kept after done");
   // busy is registered one cycle behind the engine, so a broadcast request leads it by a cycle
   busy_with_req_a: assert property (bus1_gear_req |=> bus1_busy)
      else $error("gear request while not busy");
   addr_range_a: assert property (bus1_gear_req && bus1_gear_op == 3'b011
      |-> bus1_gear_addr inside {[5'h01:5'h10]})
      else $error("program address outside 1..16");
   addr_range_two_a: assert property (bus2_gear_req && bus2_gear_op == 3'b011
      |-> bus2_gear_addr inside {[5'h01:5'h10]})
      else $error("second bus program address outside 1..16");
   forget_single_a: assert property ($rose(bus1_gear_req) && bus1_gear_op inside {3'b001, 3'b010}
      |-> ##[1:2] !bus1_single_ok)
      else $error("single control kept after address loss");
endmodule
bind lbcc_top lbcc_top_sva u_lbcc_top_sva (.*);
`default_nettype wire

// *** tb/lbcc_gear_model.sv ***
// lamp gear population on one bus: counts loose units, tracks taken addresses
`timescale 1ns/1ns
`default_nettype none
module lbcc_gear_model #(
   parameter int LAT = 1
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       gear_req,
   input  wire logic [2:0] gear_op,
   input  wire logic [4:0] gear_addr,
   output logic            gear_done,
   output logic            gear_found,
   input  wire logic       swap,
   input  wire logic [4:0] swap_addr
);
   logic [15:0] held_q;
   logic [4:0]  loose_q;
   logic        hit_q;
   int          wait_q;
   // found is only meaningful with done; otherwise show the inverse
   assign gear_found = gear_done ? hit_q : ~hit_q;
   always @(posedge clock) begin
      if (!rst_n) begin
         gear_done <= 1'b0;
         held_q <= 16'h0000;
         loose_q <= 5'h00;
         hit_q <= 1'b0;
         wait_q <= 0;
      end else begin
         // swap with address 0 plugs fresh gear, else replaces that unit
         if (swap && swap_addr != 5'h00)
            held_q[swap_addr - 5'h01] <= 1'b0;
         if (swap)
            loose_q <= loose_q + 5'h01;
         if (gear_req && !gear_done && wait_q < LAT)
            wait_q <= wait_q + 1;
         else if (gear_req && !gear_done) begin
            wait_q <= 0;
            gear_done <= 1'b1;
            if (gear_op != 3'b011) begin
               loose_q <= loose_q + 5'($countones(held_q));
               held_q <= 16'h0000;
            end else begin
               // only a unit without an address answers programming
               hit_q <= loose_q != 5'h00 && !held_q[gear_addr - 5'h01];
               if (loose_q != 5'h00 && !held_q[gear_addr - 5'h01]) begin
                  held_q[gear_addr - 5'h01] <= 1'b1;
                  loose_q <= loose_q - 5'h01;
               end
            end
         end else begin
            gear_done <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/lbcc_top_tb.sv ***
// self-checking bench of the two-channel commissioning controller
`timescale 1ns/1ns
`default_nettype none
module lbcc_top_tb;
   typedef struct {logic [15:0] a, d, r; logic we, re;} lbcc_row_type;
   logic        clock = 1'b0, rst_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rd_v;
   logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_ack, reg_err, err_v, ack_v;
   logic [15:0] flags1 = 16'h0000, flags2 = 16'h0000;
   logic        req1, req2, done1, done2, found1, found2;
   logic [2:0]  op1, op2;
   logic [4:0]  addr1, addr2;
   logic        ok1, ok2, busy1, busy2;
   logic        swap1 = 1'b0, swap2 = 1'b0;
   logic [4:0]  swap_addr1 = 5'h00, swap_addr2 = 5'h00;
   int          num_errors = 0, samples_checked = 0;
   lbcc_row_type rows [5] = '{'{16'h9D3E, 16'h07FF, 16'h07FF, 1'b0, 1'b0},
      '{16'h9D3F, 16'h0555, 16'h0555, 1'b0, 1'b0}, '{16'h7611, 16'hFFFF, 16'h0000, 1'b1, 1'b0},
      '{16'h7612, 16'hFFFF, 16'h0000, 1'b1, 1'b0}, '{16'h1234, 16'hFFFF, 16'h0000, 1'b1, 1'b1}};
   always #10 clock = ~clock;
   lbcc_top u_lbcc_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_err(reg_err), .bus1_fault_flags(flags1), .bus2_fault_flags(flags2),
      .bus1_gear_req(req1), .bus1_gear_op(op1), .bus1_gear_addr(addr1), .bus1_gear_done(done1),
      .bus1_gear_found(found1), .bus2_gear_req(req2), .bus2_gear_op(op2), .bus2_gear_addr(addr2),
      .bus2_gear_done(done2), .bus2_gear_found(found2), .bus1_single_ok(ok1),
      .bus2_single_ok(ok2), .bus1_busy(busy1), .bus2_busy(busy2));
   lbcc_gear_model #(.LAT(1)) u_lbcc_gear_model_a (.clock(clock), .rst_n(rst_n), .gear_req(req1),
      .gear_op(op1), .gear_addr(addr1), .gear_done(done1), .gear_found(found1),
      .swap(swap1), .swap_addr(swap_addr1));
   // slow second bus keeps its engine busy longer
   lbcc_gear_model #(.LAT(6)) u_lbcc_gear_model_b (.clock(clock), .rst_n(rst_n), .gear_req(req2),
      .gear_op(op2), .gear_addr(addr2), .gear_done(done2), .gear_found(found2),
      .swap(swap2), .swap_addr(swap_addr2));
   // ==================================================
   // tasks
   task automatic wrap_up();
      $display("compared %0d, mismatched %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
      err_v = reg_err;
      ack_v = reg_ack;
   endtask
   task automatic wait_idle(input logic b2);
      int n;
      n = 0;
      repeat (4) @(posedge clock);
      while ((b2 ? busy2 : busy1) !== 1'b0) begin
         @(posedge clock);
         n++;
         if (n > 3000) begin
            num_errors++;
            wrap_up();
         end
      end
   endtask
   task automatic run(input logic b2, input logic [15:0] d);
      acc(1'b1, b2 ? 16'h9D3F : 16'h9D3E, d);
      wait_idle(b2);
   endtask
   task automatic plug(input logic b2, input logic [4:0] a);
      @(posedge clock);
      if (b2) {swap2, swap_addr2} <= {1'b1, a};
      else {swap1, swap_addr1} <= {1'b1, a};
      @(posedge clock);
      {swap1, swap2} <= 2'b00;
   endtask
   // ==================================================
   // sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      chk({15'h0000, ok1}, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, rows[i].a, rows[i].d);
         chk({15'h0000, err_v}, {15'h0000, rows[i].we});
         chk({15'h0000, ack_v}, 16'h0001);
         acc(1'b0, rows[i].a, 16'h0000);
         chk(rd_v, rows[i].r);
         chk({15'h0000, ack_v}, 16'h0001);
         chk({15'h0000, err_v}, {15'h0000, rows[i].re});
      end
      $display("register table test done");
      for (int k = 0; k < 3; k++) plug(1'b0, 5'h00);
      run(1'b0, 16'h4000);
      chk(u_lbcc_gear_model_a.held_q, 16'h0007);
      chk({15'h0000, ok1}, 16'h0001);
      for (int k = 0; k < 2; k++) plug(1'b0, 5'h00);
      run(1'b0, 16'h4000);
      chk(u_lbcc_gear_model_a.held_q, 16'h0007);
      run(1'b0, 16'h0000);
      run(1'b0, 16'h4000);
      chk(u_lbcc_gear_model_a.held_q, 16'h001F);
      $display("add test done");
      plug(1'b0, 5'h02);
      run(1'b0, 16'h2000);
      chk(u_lbcc_gear_model_a.held_q, 16'h001D);
      flags1 <= 16'h0002;
      run(1'b0, 16'h0000);
      run(1'b0, 16'h2000);
      chk(u_lbcc_gear_model_a.held_q, 16'h001F);
      $display("replace test done");
      run(1'b0, 16'h8000);
      chk(u_lbcc_gear_model_a.held_q, 16'h0000);
      chk({15'h0000, ok1}, 16'h0000);
      acc(1'b1, 16'h9D3E, 16'h1000);
      acc(1'b1, 16'h9D3E, 16'h9000);
      wait_idle(1'b0);
      chk(16'($countones(u_lbcc_gear_model_a.held_q)), 16'h0005);
      acc(1'b0, 16'h7611, 16'h0000);
      chk(rd_v, 16'h0064);
      $display("discovery test done");
      for (int k = 0; k < 2; k++) plug(1'b1, 5'h00);
      run(1'b1, 16'h4000);
      chk(u_lbcc_gear_model_b.held_q, 16'h0003);
      run(1'b1, 16'h0800);
      chk(u_lbcc_gear_model_b.held_q, 16'h0000);
      chk({15'h0000, ok2}, 16'h0000);
      run(1'b1, 16'h1800);
      chk(16'($countones(u_lbcc_gear_model_b.held_q)), 16'h0002);
      acc(1'b0, 16'h7612, 16'h0000);
      chk(rd_v, 16'h0064);
      $display("second bus test done");
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      acc(1'b0, 16'h9D3F, 16'h0000);
      chk(rd_v, 16'h0000);
      chk({15'h0000, ok1}, 16'h0000);
      $display("second reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
